// >>> testbench/srt_mem_model.sv
`timescale 1ns/1ps
// Data memory on the far side: byte array, big-endian words
module srt_mem_model (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic mem_byte,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [7:0] mem [0:1023];
  logic [9:0] a;
  assign a = mem_addr[9:0];
  initial mem_rdata = 16'hA5A5;
  // Read data is good only in the cycle after the strobe; it toggles otherwise
  always @(posedge clk) begin
    if (mem_rd) begin
      mem_rdata <= mem_byte ? {8'h00, mem[a]} : {mem[a], mem[a + 10'h001]};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr && mem_byte) begin
      mem[a] <= mem_wdata[7:0];
    end else if (mem_wr) begin
      mem[a] <= mem_wdata[15:8];
      mem[a + 10'h001] <= mem_wdata[7:0];
    end
  end
  // Preload helper, used only before the search commands run
  task put_word(input logic [9:0] ad, input logic [15:0] v);
    mem[ad] = v[15:8];
    mem[ad + 10'h001] = v[7:0];
  endtask
endmodule

// >>> testbench/srt_unit_tb.sv
`timescale 1ns/1ps
`include "srt_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); num_errors++; end end
`define BITAT(k) exp_mem[ab + (bt + (k)) / 8][(bt + (k)) % 8]
module srt_unit_tb;
  import srt_pkg::*;
  logic clk, rst, reg_wr, reg_rd, cmd_valid, cmd_bit, done, busy;
  logic zero_status_flag, overflow_status_flag, mem_rd, mem_wr, mem_byte;
  logic [7:0] reg_addr, cmd_count;
  logic [31:0] reg_wdata, reg_rdata, cmd_in, result_out, s;
  logic [2:0] cmd_cmp;
  srt_op_t cmd_op;
  srt_width_t cmd_width;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [7:0] exp_mem [0:1023];
  int num_errors, n_tests;
  srt_unit i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_width(cmd_width), .cmd_in(cmd_in), .cmd_count(cmd_count),
    .cmd_cmp(cmd_cmp), .cmd_bit(cmd_bit), .result_out(result_out), .done(done),
    .busy(busy), .zero_status_flag(zero_status_flag),
    .overflow_status_flag(overflow_status_flag), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  srt_mem_model i_mem (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task finish_test;
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Register port: one-cycle strobes, read data stands only in the next cycle
  task reg_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task issue(srt_op_t op, srt_width_t w, logic [31:0] in, logic [7:0] n, logic [2:0] c,
             logic b);
    @(posedge clk);
    cmd_valid <= 1'b1; cmd_op <= op; cmd_width <= w; cmd_in <= in;
    cmd_count <= n; cmd_cmp <= c; cmd_bit <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  // Bounded wait, so a lost completion cannot hang the run
  task wait_done;
    int i;
    i = 0;
    while (done !== 1'b1 && i < 1000) begin
      @(posedge clk);
      #1 i++;
    end
    `CHK(done, 1'b1)
  endtask
  // Reference shifter: {zero, overflow, result}
  function automatic logic [33:0] sr_ref(srt_op_t op, srt_width_t w, logic [31:0] in,
                                         logic [7:0] cnt);
    int wd, n;
    logic [31:0] v, m;
    logic o;
    wd = (w == SRT_W8) ? 8 : (w == SRT_W16) ? 16 : 32;
    m = (wd == 32) ? 32'hFFFFFFFF : (32'h1 << wd) - 32'h1;
    v = in & m;
    o = 1'b0;
    n = (op == SRT_OP_SHL || op == SRT_OP_SHR) ? ((int'(cnt) > wd) ? wd : int'(cnt))
        : int'(cnt) % wd;
    for (int k = 0; k < n; k++) begin
      if (op == SRT_OP_SHL || op == SRT_OP_ROL) begin
        o = v[wd - 1];
        v = ((v << 1) & m) | ((op == SRT_OP_ROL && o) ? 32'h1 : 32'h0);
      end else begin
        o = v[0];
        v = (v >> 1) | ((op == SRT_OP_ROR && o) ? (32'h1 << (wd - 1)) : 32'h0);
      end
    end
    return {v == 32'h0, o, v};
  endfunction
  task sr(srt_op_t op, srt_width_t w, logic [31:0] in, logic [7:0] cnt);
    logic [33:0] e;
    e = sr_ref(op, w, in, cnt);
    issue(op, w, in, cnt, 3'h0, 1'b0);
    `CHK({done, zero_status_flag, overflow_status_flag, result_out}, {1'b1, e})
  endtask
  task find(logic [15:0] org, logic [15:0] st, logic [15:0] pat, logic [2:0] c,
            logic [15:0] ei, logic ef);
    reg_w(`SRT_REG_TABLE_ORIGIN, {16'h0000, org});
    reg_w(`SRT_REG_START_INDEX, {16'h0000, st});
    reg_w(`SRT_REG_SEARCH_PATTERN, {16'h0000, pat});
    issue(SRT_OP_FIND, SRT_W16, 32'h0, 8'h00, c, 1'b0);
    `CHK(busy, 1'b1)
    wait_done;
    rd(`SRT_REG_START_INDEX, s);
    `CHK(s, {16'h0000, ei})
    rd(`SRT_REG_STATUS, s);
    `CHK(s[`SRT_ST_FOUND], ef)
  endtask
  // Bit register step; the expected image moves in exp_mem
  task bsr(logic [15:0] ab, logic [2:0] bt, logic [7:0] len, logic din, logic bad);
    int l, m;
    logic z0, eo;
    z0 = zero_status_flag;
    eo = overflow_status_flag;
    l = int'($signed(len));
    m = (l < 0) ? -l : l;
    reg_w(`SRT_REG_BSR_ANCHOR, {13'h0000, bt, ab});
    reg_w(`SRT_REG_BSR_LENGTH, {24'h000000, len});
    if (!bad && l > 0) begin
      eo = `BITAT(m - 1);
      for (int k = m - 1; k > 0; k--) `BITAT(k) = `BITAT(k - 1);
      `BITAT(0) = din;
    end else if (!bad) begin
      eo = `BITAT(0);
      for (int k = 0; k < m - 1; k++) `BITAT(k) = `BITAT(k + 1);
      `BITAT(m - 1) = din;
    end
    issue(SRT_OP_BSR, SRT_W8, 32'h0, 8'h00, 3'h0, din);
    if (bad) `CHK(done, 1'b1)
    else wait_done;
    `CHK({zero_status_flag, overflow_status_flag}, {z0, eo})
    rd(`SRT_REG_STATUS, s);
    `CHK(s[`SRT_ST_LEN_ERR], bad)
    `CHK(s[`SRT_ST_OVERFLOW], eo)
    for (int i = 16'h0318; i < 16'h0330; i++) `CHK(i_mem.mem[i], exp_mem[i])
  endtask
  // Hang guard, well above the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test;
  end
  // Main sequence
  initial begin
    num_errors = 0; n_tests = 0; rst = 1'b1; reg_wr = 0; reg_rd = 0; reg_addr = 8'h00;
    reg_wdata = 32'h0; cmd_valid = 0; cmd_op = SRT_OP_SHL; cmd_width = SRT_W8;
    cmd_in = 32'h0; cmd_count = 8'h00; cmd_cmp = 3'h0; cmd_bit = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 8'h18; a += 4) begin
      rd(8'(a), s);
      `CHK(s, 32'h0)
    end
    reg_w(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, s);
    `CHK(s, 32'h0)
    reg_w(`SRT_REG_START_INDEX, 32'h1234_ABCD);
    rd(`SRT_REG_START_INDEX, s);
    `CHK(s, 32'h0000_ABCD)
    sr(SRT_OP_SHL, SRT_W8, 32'h81, 8'h01);
    sr(SRT_OP_SHL, SRT_W8, 32'h5A, 8'h00);
    sr(SRT_OP_SHR, SRT_W8, 32'h81, 8'h09);
    sr(SRT_OP_SHR, SRT_W8, 32'hFF00, 8'h01);
    sr(SRT_OP_SHL, SRT_W16, 32'h8001, 8'h10);
    sr(SRT_OP_SHR, SRT_W16, 32'h8000, 8'h01);
    sr(SRT_OP_SHL, SRT_W32, 32'h1, 8'hC8);
    sr(SRT_OP_SHR, SRT_W32, 32'h8000_0000, 8'h1F);
    sr(SRT_OP_ROL, SRT_W8, 32'h81, 8'h09);
    sr(SRT_OP_ROR, SRT_W16, 32'h0001, 8'h11);
    sr(SRT_OP_ROL, SRT_W32, 32'h8000_0000, 8'h20);
    sr(SRT_OP_ROR, SRT_W8, 32'h01, 8'h08);
    sr(SRT_OP_ROR, SRT_W32, 32'h1234_5678, 8'h04);
    sr(SRT_OP_ROL, SRT_W16, 32'h00F0, 8'hFF);
    // Table layout: limit word, count word, entries
    i_mem.put_word(10'h0FE, 16'h0007);
    i_mem.put_word(10'h100, 16'h0005);
    i_mem.put_word(10'h102, 16'd10);
    i_mem.put_word(10'h104, 16'd20);
    i_mem.put_word(10'h106, 16'hFFFB);
    i_mem.put_word(10'h108, 16'd20);
    i_mem.put_word(10'h10A, 16'd30);
    i_mem.put_word(10'h200, 16'd120);
    for (int i = 0; i <= 100; i++) i_mem.put_word(10'(16'h202 + 2 * i), 16'h0000);
    i_mem.put_word(10'(16'h202 + 2 * 99), 16'h7777);
    i_mem.put_word(10'(16'h202 + 2 * 100), 16'h5555);
    find(16'h0100, 16'd0, 16'd20, `SRT_CMP_EQ, 16'd1, 1'b1);
    find(16'h0100, 16'd2, 16'd20, `SRT_CMP_EQ, 16'd3, 1'b1);
    find(16'h0100, 16'd0, 16'd10, `SRT_CMP_NE, 16'd1, 1'b1);
    find(16'h0100, 16'd0, 16'd0, `SRT_CMP_LT, 16'd2, 1'b1);
    find(16'h0100, 16'd0, 16'd25, `SRT_CMP_GT, 16'd4, 1'b1);
    find(16'h0100, 16'd0, 16'd99, `SRT_CMP_EQ, 16'd5, 1'b0);
    find(16'h0100, 16'd7, 16'd10, `SRT_CMP_EQ, 16'd5, 1'b0);
    find(16'h0200, 16'd98, 16'h7777, `SRT_CMP_EQ, 16'd99, 1'b1);
    find(16'h0200, 16'd0, 16'h5555, `SRT_CMP_EQ, 16'd120, 1'b0);
    for (int i = 16'h0318; i < 16'h0330; i++) begin
      exp_mem[i] = 8'(i * 37);
      i_mem.mem[i] = 8'(i * 37);
    end
    sr(SRT_OP_SHL, SRT_W8, 32'h0, 8'h01);
    bsr(16'h0321, 3'd4, 8'd14, 1'b1, 1'b0);
    bsr(16'h0321, 3'd4, 8'hF2, 1'b0, 1'b0);
    bsr(16'h031A, 3'd7, 8'd64, 1'b1, 1'b0);
    bsr(16'h031A, 3'd7, 8'hC0, 1'b1, 1'b0);
    bsr(16'h0321, 3'd0, 8'h00, 1'b1, 1'b1);
    bsr(16'h0321, 3'd0, 8'h41, 1'b1, 1'b1);
    bsr(16'h0321, 3'd0, 8'hBF, 1'b1, 1'b1);
    finish_test;
  end
endmodule

// >>> verilog/srt_map.svh
`ifndef SRT_MAP_SVH
`define SRT_MAP_SVH

// Register byte offsets on the plain register port
`define SRT_REG_START_INDEX 8'h00
`define SRT_REG_SEARCH_PATTERN 8'h04
`define SRT_REG_TABLE_ORIGIN 8'h08
`define SRT_REG_BSR_ANCHOR 8'h0C
`define SRT_REG_BSR_LENGTH 8'h10
`define SRT_REG_STATUS 8'h14

// Anchor field layout: byte address low, bit number above it
`define SRT_ANCHOR_BIT_LSB 16
`define SRT_ANCHOR_BIT_MSB 18

// Status bit positions
`define SRT_ST_ZERO 0
`define SRT_ST_OVERFLOW 1
`define SRT_ST_BUSY 2
`define SRT_ST_FOUND 3
`define SRT_ST_LEN_ERR 4

// Reset values
`define SRT_RST_WORD16 16'h0000
`define SRT_RST_LEN 8'h00

// Compare codes of the table search
`define SRT_CMP_EQ 3'h1
`define SRT_CMP_NE 3'h2
`define SRT_CMP_LT 3'h3
`define SRT_CMP_GT 3'h4

// Limits and table layout
`define SRT_MAX_ENTRIES 100
`define SRT_BSR_MAX_LEN 64
`define SRT_ENTRY0_OFFSET 16'h0002

`endif

// >>> verilog/srt_pkg.sv
package srt_pkg;

  typedef enum logic [2:0] {
    SRT_OP_SHL = 3'b000,
    SRT_OP_SHR = 3'b001,
    SRT_OP_ROL = 3'b010,
    SRT_OP_ROR = 3'b011,
    SRT_OP_BSR = 3'b100,
    SRT_OP_FIND = 3'b101
  } srt_op_t;

  typedef enum logic [1:0] {
    SRT_W8 = 2'b00,
    SRT_W16 = 2'b01,
    SRT_W32 = 2'b10
  } srt_width_t;

  typedef enum logic [2:0] {
    SRT_S_IDLE = 3'b000,
    SRT_S_CNT = 3'b001,
    SRT_S_ENT = 3'b010,
    SRT_S_BRD = 3'b011,
    SRT_S_BCALC = 3'b100,
    SRT_S_BWR = 3'b101
  } srt_state_t;

endpackage

// >>> verilog/srt_unit.sv
// Function
// - Compare codes 1..4 select = <> < >
// - Search from start index, stop at hit
// - No hit writes entry count to index
// - Entries numbered 0..99, at most 100
// - Table origin points at entry-count word
// - Anchor bit plus signed length picks direction
// - Shift-plus enters LSB, MSB leaves
// - Shift-minus enters MSB, LSB leaves
// - Leaving bit goes to overflow flag
// - Bit register length at most 64
// - MSB location from byte, bit, length
// - One bit position per execution
// - Logical shifts fill zeros into result
// - Shift count saturates at operand width
// - Nonzero shift puts last bit in overflow
// - Rotate count reduced modulo operand width
// - Zero rotate count means no rotation
// - Rotation copies last bit to overflow
// - Operands are unsigned bit patterns
// - Shifts and rotates update both flags
// - Append table: max length, count, entries
`timescale 1ns/1ps
`include "srt_map.svh"
module srt_unit #(
  parameter int MAX_ENTRIES = `SRT_MAX_ENTRIES,
  parameter int BSR_MAX = `SRT_BSR_MAX_LEN
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire srt_pkg::srt_op_t cmd_op,
  input wire srt_pkg::srt_width_t cmd_width,
  input wire logic [31:0] cmd_in,
  input wire logic [7:0] cmd_count,
  input wire logic [2:0] cmd_cmp,
  input wire logic cmd_bit,
  output logic [31:0] result_out,
  output logic done,
  output logic busy,
  output logic zero_status_flag,
  output logic overflow_status_flag,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_byte,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata
);
  import srt_pkg::*;
  srt_state_t state_ff;
  logic [15:0] start_index_ff, search_pattern_ff, table_origin_ff, bsr_byte_ff;
  logic [2:0] bsr_bit_ff, cmp_ff;
  logic [7:0] bsr_len_ff;
  logic [15:0] cnt_ff, ent_idx_ff;
  logic [71:0] buf_ff;
  logic [3:0] idx_ff;
  logic bsr_data_ff, rd_seen_ff, found_ff, len_err_ff;
  logic [31:0] result_ff, rdata_ff;
  logic done_ff, busy_ff, zero_ff, ovf_ff;
  logic mem_rd_ff, mem_wr_ff, mem_byte_ff;
  logic [15:0] mem_addr_ff, mem_wdata_ff;
  function automatic logic [5:0] width_bits(input srt_width_t w);
    case (w)
      SRT_W8: width_bits = 6'h08;
      SRT_W16: width_bits = 6'h10;
      default: width_bits = 6'h20;
    endcase
  endfunction
  // Entries and pattern compare as signed words; unknown codes never hit
  // compare code decode
  function automatic logic cmp_hit(input logic [2:0] c, input logic [15:0] e,
                                   input logic [15:0] p);
    case (c)
      `SRT_CMP_EQ: cmp_hit = (e == p);
      `SRT_CMP_NE: cmp_hit = (e != p);
      `SRT_CMP_LT: cmp_hit = ($signed(e) < $signed(p));
      `SRT_CMP_GT: cmp_hit = ($signed(e) > $signed(p));
      default: cmp_hit = 1'b0;
    endcase
  endfunction
  // Command acceptance, only while idle
  wire is_idle = (state_ff == SRT_S_IDLE);
  wire take = cmd_valid && is_idle;
  // Shifts and rotates are the four codes with the top bit clear
  wire alu_op = !cmd_op[2];
  wire alu_take = take && alu_op;
  wire find_take = take && (cmd_op == SRT_OP_FIND);
  wire bsr_take = take && (cmd_op == SRT_OP_BSR);
  // Operand masked to width, so no sign bits ever reach the result
  // unsigned width mask
  wire [5:0] w_bits = width_bits(cmd_width);
  wire [32:0] wmask_x = (33'h0_0000_0001 << w_bits) - 33'h0_0000_0001;
  wire [31:0] wmask = wmask_x[31:0];
  wire [31:0] in_m = cmd_in & wmask;
  wire [5:0] sh_cnt = (cmd_count >= {2'b00, w_bits}) ? w_bits : cmd_count[5:0];
  wire [5:0] rot_cnt = cmd_count[5:0] & (w_bits - 6'h01);
  wire [63:0] shl_wide = {32'h0000_0000, in_m} << sh_cnt;
  wire [31:0] shl_res = shl_wide[31:0] & wmask;
  wire [31:0] shr_res = in_m >> sh_cnt;
  wire [5:0] shl_idx = w_bits - sh_cnt;
  wire [5:0] shr_idx = sh_cnt - 6'h01;
  wire shl_out = (sh_cnt != 6'h00) ? in_m[shl_idx[4:0]] : 1'b0;
  wire shr_out = (sh_cnt != 6'h00) ? in_m[shr_idx[4:0]] : 1'b0;
  // Full-width complement shift of 32 yields zero, so count 0 is harmless
  wire [5:0] rot_back = w_bits - rot_cnt;
  wire [31:0] rol_res = ((in_m << rot_cnt) | (in_m >> rot_back)) & wmask;
  wire [31:0] ror_res = ((in_m >> rot_cnt) | (in_m << rot_back)) & wmask;
  wire [5:0] top_idx = w_bits - 6'h01;
  wire rot_none = (rot_cnt == 6'h00);
  wire rol_out = rot_none ? 1'b0 : rol_res[0];
  wire ror_out = rot_none ? 1'b0 : ror_res[top_idx[4:0]];
  // Result and overflow selection
  wire [31:0] alu_res = (cmd_op == SRT_OP_SHL) ? shl_res :
                        (cmd_op == SRT_OP_SHR) ? shr_res :
                        (cmd_op == SRT_OP_ROL) ? (rot_none ? in_m : rol_res) :
                        (rot_none ? in_m : ror_res);
  wire alu_ovf = (cmd_op == SRT_OP_SHL) ? shl_out :
                 (cmd_op == SRT_OP_SHR) ? shr_out :
                 (cmd_op == SRT_OP_ROL) ? rol_out : ror_out;
  wire len_neg = bsr_len_ff[7];
  wire [7:0] len_mag = len_neg ? (8'h00 - bsr_len_ff) : bsr_len_ff;
  wire len_ok = (len_mag != 8'h00) && ({24'h0, len_mag} <= BSR_MAX);
  wire [6:0] span = {4'h0, bsr_bit_ff} + len_mag[6:0] - 7'h01;
  wire [3:0] last_byte = span[6:3];
  wire [6:0] p_lsb = {4'h0, bsr_bit_ff};
  wire [71:0] lsb_one = 72'h1 << p_lsb;
  wire [71:0] msb_one = 72'h1 << span;
  wire [71:0] fmask = ((72'h1 << len_mag) - 72'h1) << p_lsb;
  wire [71:0] keep = buf_ff & ~fmask;
  // data in at LSB, MSB leaves
  wire [71:0] plus_new = keep | ((buf_ff << 1) & fmask & ~lsb_one) |
                         (bsr_data_ff ? lsb_one : 72'h0);
  // data in at MSB, LSB leaves
  wire [71:0] minus_new = keep | ((buf_ff >> 1) & fmask & ~msb_one) |
                          (bsr_data_ff ? msb_one : 72'h0);
  wire bsr_out = len_neg ? buf_ff[p_lsb] : buf_ff[span];
  wire [6:0] byte_pos = {idx_ff, 3'b000};
  wire [15:0] byte_addr = bsr_byte_ff + {12'h000, idx_ff};
  wire [15:0] cnt_now = (state_ff == SRT_S_CNT) ? mem_rdata : cnt_ff;
  wire [15:0] lim = ({16'h0, cnt_now} > MAX_ENTRIES) ? 16'(MAX_ENTRIES) : cnt_now;
  wire [15:0] idx_inc = ent_idx_ff + 16'h0001;
  wire [15:0] nxt_ent_idx = (state_ff == SRT_S_CNT) ? ent_idx_ff : idx_inc;
  wire [15:0] ent_addr = table_origin_ff + `SRT_ENTRY0_OFFSET + {nxt_ent_idx[14:0], 1'b0};
  wire hit = cmp_hit(cmp_ff, mem_rdata, search_pattern_ff);
  wire cnt_seen = (state_ff == SRT_S_CNT) && rd_seen_ff;
  wire ent_seen = (state_ff == SRT_S_ENT) && rd_seen_ff;
  wire srch_hit = ent_seen && hit;
  wire srch_miss = (cnt_seen && (ent_idx_ff >= lim)) || (ent_seen && !hit && (idx_inc >= lim));
  wire srch_next = (cnt_seen || ent_seen) && !srch_hit && !srch_miss;
  // Register port decode
  wire wr_start = reg_wr && (reg_addr == `SRT_REG_START_INDEX);
  wire wr_pattern = reg_wr && (reg_addr == `SRT_REG_SEARCH_PATTERN);
  wire wr_origin = reg_wr && (reg_addr == `SRT_REG_TABLE_ORIGIN);
  wire wr_anchor = reg_wr && (reg_addr == `SRT_REG_BSR_ANCHOR);
  wire wr_len = reg_wr && (reg_addr == `SRT_REG_BSR_LENGTH);
  wire [31:0] status_word = {27'h0, len_err_ff, found_ff, busy_ff, ovf_ff, zero_ff};
  wire [31:0] rd_mux =
    (reg_addr == `SRT_REG_START_INDEX) ? {16'h0, start_index_ff} :
    (reg_addr == `SRT_REG_SEARCH_PATTERN) ? {16'h0, search_pattern_ff} :
    (reg_addr == `SRT_REG_TABLE_ORIGIN) ? {16'h0, table_origin_ff} :
    (reg_addr == `SRT_REG_BSR_ANCHOR) ? {13'h0, bsr_bit_ff, bsr_byte_ff} :
    (reg_addr == `SRT_REG_BSR_LENGTH) ? {24'h0, bsr_len_ff} :
    (reg_addr == `SRT_REG_STATUS) ? status_word : 32'h0000_0000;
  // Search result beats a bus write in the same cycle
  // hit leaves its position
  wire [15:0] nxt_start_index = srch_hit ? ent_idx_ff :
                                srch_miss ? cnt_now :
                                wr_start ? reg_wdata[15:0] : start_index_ff;
  // Software registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_index_ff <= `SRT_RST_WORD16;
      search_pattern_ff <= `SRT_RST_WORD16;
      table_origin_ff <= `SRT_RST_WORD16;
      bsr_byte_ff <= `SRT_RST_WORD16;
      bsr_bit_ff <= 3'h0;
      bsr_len_ff <= `SRT_RST_LEN;
      rdata_ff <= 32'h0000_0000;
    end else begin
      start_index_ff <= nxt_start_index;
      if (wr_pattern) search_pattern_ff <= reg_wdata[15:0];
      if (wr_origin) table_origin_ff <= reg_wdata[15:0];
      if (wr_anchor) bsr_byte_ff <= reg_wdata[15:0];
      if (wr_anchor) bsr_bit_ff <= reg_wdata[`SRT_ANCHOR_BIT_MSB:`SRT_ANCHOR_BIT_LSB];
      if (wr_len) bsr_len_ff <= reg_wdata[7:0];
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  // Sequencer of the multi-cycle operations; memory answers a cycle after a read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= SRT_S_IDLE;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_byte_ff <= 1'b0;
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 16'h0000;
      rd_seen_ff <= 1'b0;
      idx_ff <= 4'h0;
      ent_idx_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      cmp_ff <= 3'h0;
      buf_ff <= 72'h0;
      bsr_data_ff <= 1'b0;
    end else begin
      rd_seen_ff <= mem_rd_ff;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      unique case (state_ff)
        SRT_S_IDLE: begin
          if (find_take) begin
            state_ff <= SRT_S_CNT;
            ent_idx_ff <= start_index_ff;
            cmp_ff <= cmd_cmp;
            mem_rd_ff <= 1'b1;
            mem_byte_ff <= 1'b0;
            mem_addr_ff <= table_origin_ff;
          end else if (bsr_take && len_ok) begin
            state_ff <= SRT_S_BRD;
            idx_ff <= 4'h0;
            bsr_data_ff <= cmd_bit;
            mem_rd_ff <= 1'b1;
            mem_byte_ff <= 1'b1;
            mem_addr_ff <= bsr_byte_ff;
          end
        end
        SRT_S_CNT, SRT_S_ENT: begin
          if (cnt_seen) cnt_ff <= mem_rdata;
          if (srch_hit || srch_miss) state_ff <= SRT_S_IDLE;
          if (srch_next) begin
            state_ff <= SRT_S_ENT;
            ent_idx_ff <= nxt_ent_idx;
            mem_rd_ff <= 1'b1;
            mem_addr_ff <= ent_addr;
          end
        end
        SRT_S_BRD: begin
          if (rd_seen_ff) begin
            buf_ff[byte_pos +: 8] <= mem_rdata[7:0];
            idx_ff <= (idx_ff == last_byte) ? 4'h0 : idx_ff + 4'h1;
            state_ff <= (idx_ff == last_byte) ? SRT_S_BCALC : SRT_S_BRD;
            mem_rd_ff <= (idx_ff != last_byte);
            mem_addr_ff <= byte_addr + 16'h0001;
          end
        end
        SRT_S_BCALC: begin
          buf_ff <= len_neg ? minus_new : plus_new;
          state_ff <= SRT_S_BWR;
        end
        SRT_S_BWR: begin
          mem_wr_ff <= 1'b1;
          mem_addr_ff <= byte_addr;
          mem_wdata_ff <= {8'h00, buf_ff[byte_pos +: 8]};
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == last_byte) state_ff <= SRT_S_IDLE;
        end
        default: state_ff <= SRT_S_IDLE;
      endcase
    end
  end
  // Flags, result and completion
  wire bsr_end = (state_ff == SRT_S_BWR) && (idx_ff == last_byte);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_ff <= 32'h0000_0000;
      zero_ff <= 1'b0;
      ovf_ff <= 1'b0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
      found_ff <= 1'b0;
      len_err_ff <= 1'b0;
    end else begin
      done_ff <= alu_take || srch_hit || srch_miss || bsr_end || (bsr_take && !len_ok);
      busy_ff <= (find_take || (bsr_take && len_ok)) ||
                 (!is_idle && !(srch_hit || srch_miss || bsr_end));
      if (alu_take) result_ff <= alu_res;
      // both flags on every shift or rotate
      if (alu_take) zero_ff <= (alu_res == 32'h0000_0000);
      if (alu_take) ovf_ff <= alu_ovf;
      else if (state_ff == SRT_S_BCALC) ovf_ff <= bsr_out;
      if (srch_hit || srch_miss) found_ff <= srch_hit;
      if (bsr_take) len_err_ff <= !len_ok;
    end
  end
  assign reg_rdata = rdata_ff;
  assign result_out = result_ff;
  assign done = done_ff;
  assign busy = busy_ff;
  assign zero_status_flag = zero_ff;
  assign overflow_status_flag = ovf_ff;
  assign mem_rd = mem_rd_ff;
  assign mem_wr = mem_wr_ff;
  assign mem_byte = mem_byte_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  // Checks on the datapath and sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  shl_saturate_a: assert property (
    alu_take && cmd_op == SRT_OP_SHL && cmd_width == SRT_W8 && cmd_count >= 8'h08
    |=> result_ff == 32'h0 && zero_ff && ovf_ff == $past(cmd_in[0]))
    else $error("byte left shift did not saturate");
  shr_last_bit_a: assert property (
    alu_take && cmd_op == SRT_OP_SHR && cmd_width == SRT_W16 && cmd_count == 8'h01
    |=> result_ff == {17'h0, $past(cmd_in[15:1])} && ovf_ff == $past(cmd_in[0]))
    else $error("word right shift by one wrong");
  rot_none_a: assert property (
    alu_take && cmd_op == SRT_OP_ROL && cmd_width == SRT_W8 && cmd_count == 8'h08
    |=> result_ff == {24'h0, $past(cmd_in[7:0])} && !ovf_ff)
    else $error("rotate by width changed the operand");
  ror_wrap_a: assert property (
    alu_take && cmd_op == SRT_OP_ROR && cmd_width == SRT_W32 && cmd_count == 8'h21
    |=> result_ff == {$past(cmd_in[0]), $past(cmd_in[31:1])} && ovf_ff == $past(cmd_in[0]))
    else $error("modulo rotate right wrong");
  zero_flag_a: assert property (
    $past(alu_take) |-> zero_ff == (result_ff == 32'h0) && done_ff)
    else $error("zero flag disagrees with result");
  find_miss_a: assert property (
    cnt_seen && {16'h0, mem_rdata} <= 16'(MAX_ENTRIES) && ent_idx_ff >= mem_rdata
    |=> start_index_ff == $past(mem_rdata) && !found_ff && done_ff)
    else $error("search miss did not write entry count");
  find_hit_a: assert property (
    srch_hit |=> start_index_ff == $past(ent_idx_ff) && found_ff && !busy_ff)
    else $error("search hit index wrong");
  find_origin_a: assert property (
    find_take |=> mem_rd_ff && mem_addr_ff == $past(table_origin_ff) ##2 !busy_ff || mem_rd_ff)
    else $error("search did not read the count word first");
  find_limit_a: assert property (
    state_ff == SRT_S_ENT |-> {16'h0, ent_idx_ff} < MAX_ENTRIES)
    else $error("search ran past the entry limit");
  bsr_len_a: assert property (
    bsr_take && !len_ok |=> is_idle && len_err_ff && done_ff)
    else $error("overlong bit register accepted");
  bsr_plus_a: assert property (
    state_ff == SRT_S_BCALC && !len_neg
    |=> ovf_ff == $past(buf_ff[span]) && buf_ff[$past(p_lsb)] == $past(bsr_data_ff))
    else $error("shift-plus bit movement wrong");
  bsr_minus_a: assert property (
    state_ff == SRT_S_BCALC && len_neg
    |=> ovf_ff == $past(buf_ff[p_lsb]) && buf_ff[$past(span)] == $past(bsr_data_ff))
    else $error("shift-minus bit movement wrong");
  find_hit_c: cover property (srch_hit);
  find_miss_c: cover property (srch_miss && ent_seen);
  bsr_multi_c: cover property (bsr_end && last_byte == 4'h8);
  rot_c: cover property (alu_take && cmd_op == SRT_OP_ROL && !rot_none);
endmodule
